// [src/lpc_consts.vh]
// Constants for the low-power recalibration and vector access block
`ifndef LPC_CONSTS_VH
`define LPC_CONSTS_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define LPC_OFS_PIN_CFG   8'h6B
`define LPC_OFS_SOFT_TRIG 8'h6C
`define LPC_OFS_LP_CTRL   8'h6E
`define LPC_OFS_DATA_EN   8'h70
`define LPC_OFS_DATA      8'h71
`define LPC_OFS_STATUS    8'h6A
`define LPC_OFS_BG_CTRL   8'h60
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LPC_SLEEP_HI      7
`define LPC_SLEEP_LO      5
`define LPC_WAKE_HI       4
`define LPC_WAKE_LO       3
`define LPC_TRIGMODE_BIT  1
`define LPC_LPEN_BIT      0
`define LPC_STOPPED_BIT   1
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LPC_RST_LP_CTRL   8'h88
`define LPC_RST_SOFT_TRIG 8'h01
`define LPC_RST_PIN_CFG   8'h00
`define LPC_RST_DATA_EN   8'h00
`define LPC_RST_BG_CTRL   8'h00
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define LPC_DLY_UNIT      256
`define LPC_VEC_LEN       673
`endif

// [src/lpc_top.v]
// Low-power background recalibration sequencer and calibration vector port
//
// What this block does
// - Sleep code sets sleep, (2^k+1)x256 clocks
// - Wake code sets settle time before calibration
// - Trigger mode: sleep until trigger goes low
// - Low-power enable acts only under background calibration
// - Access enable bit gates the data port
// - Reads step through all 673 vector values
// - Writes load 673 successive vector values
// - Partial sequence leaves vector invalid
// - Stopped status follows halt state under background calibration, foreground done otherwise
// - Select bit picks software or hardware trigger
// - Software trigger bit resets high, no trigger
`timescale 1ns/10ps
`include "lpc_consts.vh"
`default_nettype none
module lpc_top #(
   parameter VEC_LEN = `LPC_VEC_LEN,  // Calibration vector length
   parameter SHIFT_W = 6              // Width of the delay exponent
) (
   // Clock, reset, enable
   input  wire        i_clock,
   input  wire        i_rst,
   input  wire        i_ce,
   // Register port
   input  wire [7:0]  i_addr,
   input  wire [7:0]  i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [7:0]  o_rdata,
   // Pins and calibration engine status
   input  wire        i_hardware_trigger_pin,
   input  wire        i_bg_halted,
   input  wire        i_fg_done,
   // Core power and calibration requests, vector valid status
   output reg         o_core_sleep,
   output reg         o_cal_start,
   output reg         o_vec_valid
);
   // ---------------------------------------------------------
   // Delay lookup
   // ---------------------------------------------------------
   // Sleep and wake exponents per code; the longest delay needs 42 bits,
   // so a narrower timer would wrap on the top codes and wake far too early
   // Exponent k for a sleep code
   function [SHIFT_W-1:0] sleep_k;
      input [2:0] code;
      begin
         case (code)
            3'd0:    sleep_k = 6'd3;
            3'd1:    sleep_k = 6'd15;
            3'd2:    sleep_k = 6'd18;
            3'd3:    sleep_k = 6'd21;
            3'd4:    sleep_k = 6'd24;
            3'd5:    sleep_k = 6'd27;
            3'd6:    sleep_k = 6'd30;
            default: sleep_k = 6'd33;
         endcase
      end
   endfunction

   // Exponent k for a wake code
   function [SHIFT_W-1:0] wake_k;
      input [1:0] code;
      begin
         case (code)
            2'd0:    wake_k = 6'd3;
            2'd1:    wake_k = 6'd18;
            2'd2:    wake_k = 6'd21;
            default: wake_k = 6'd24;
         endcase
      end
   endfunction

   // States compare with >=, so a code lowered mid-count still ends them
   // Terminal count (2^k+1)*256-1; 42 bits hold k=33
   function [41:0] dly_cnt;
      input [SHIFT_W-1:0] k;
      reg   [41:0] one;
      begin
         one     = 42'd1;
         dly_cnt = (((one << k) + one) * `LPC_DLY_UNIT) - one;
      end
   endfunction

   // ---------------------------------------------------------
   // Pin synchroniser
   // ---------------------------------------------------------
   reg        trig_meta_q;   // First stage, read only by the second
   reg        trig_sync_q;   // Safe trigger level
   reg        halt_meta_q;   // First stage of halted status
   reg        halt_sync_q;   // Safe halted level
   reg        fg_meta_q;     // First stage of foreground done
   reg        fg_sync_q;     // Safe foreground done

   // Trigger stages reset high, the idle level, so no false wake follows reset
   // Status inputs come from another domain; logic reads only second stages
   // Two flops on each asynchronous status input
   always @(posedge i_clock) begin
      if (i_rst) begin
         trig_meta_q <= 1'b1;
         trig_sync_q <= 1'b1;
         halt_meta_q <= 1'b0;
         halt_sync_q <= 1'b0;
         fg_meta_q   <= 1'b0;
         fg_sync_q   <= 1'b0;
      end else if (i_ce) begin
         trig_meta_q <= i_hardware_trigger_pin;
         trig_sync_q <= trig_meta_q;
         halt_meta_q <= i_bg_halted;
         halt_sync_q <= halt_meta_q;
         fg_meta_q   <= i_fg_done;
         fg_sync_q   <= fg_meta_q;
      end
   end

   // ---------------------------------------------------------
   // Registers
   // ---------------------------------------------------------
   // Vector memory has no reset: its contents stay unknown until a full
   // restore, so a read sweep before that returns nothing trustworthy.
   // A disable keeps the index; an enable edge or the step past the last position restarts it.
   reg  [7:0]  lp_ctrl_q;      // Low-power control
   reg  [7:0]  pin_cfg_q;      // Trigger source select in bit 0
   reg  [7:0]  soft_trig_q;    // Software trigger in bit 0
   reg  [7:0]  data_en_q;      // Vector access enable
   reg  [7:0]  bg_ctrl_q;      // Background calibration enable in bit 0
   reg  [7:0]  vec_mem [0:VEC_LEN-1];  // Stored calibration vector
   reg  [9:0]  vec_idx_q;      // Next vector position
   reg         stopped_q;      // Calibration stopped status

   wire [2:0] sleep_interval_code   = lp_ctrl_q[`LPC_SLEEP_HI:`LPC_SLEEP_LO];
   wire [1:0] wake_settle_code      = lp_ctrl_q[`LPC_WAKE_HI:`LPC_WAKE_LO];
   wire       triggered_wake_mode   = lp_ctrl_q[`LPC_TRIGMODE_BIT];
   wire       low_power_recal_enable  = lp_ctrl_q[`LPC_LPEN_BIT];
   wire       background_recal_enable = bg_ctrl_q[0];
   wire       trigger_source_select = pin_cfg_q[0];
   wire       software_trigger_bit  = soft_trig_q[0];
   // Data port ignored while access is off: no index step, reads give zero
   wire       sel_data = (i_addr == `LPC_OFS_DATA) && data_en_q[0];
   wire       last_idx = (vec_idx_q == VEC_LEN - 1);

   // Selected trigger level, low means wake
   wire       cal_trigger = trigger_source_select ? trig_sync_q
                                                  : software_trigger_bit;

   // Reserved bits are stored as written and read back unchanged
   // Register writes and the vector index
   always @(posedge i_clock) begin
      if (i_rst) begin
         lp_ctrl_q   <= `LPC_RST_LP_CTRL;
         pin_cfg_q   <= `LPC_RST_PIN_CFG;
         soft_trig_q <= `LPC_RST_SOFT_TRIG;
         data_en_q   <= `LPC_RST_DATA_EN;
         bg_ctrl_q   <= `LPC_RST_BG_CTRL;
         vec_idx_q   <= 10'd0;
         o_vec_valid <= 1'b1;
      end else if (i_ce) begin
         // Writes to unmapped offsets are dropped
         if (i_wr) begin
            case (i_addr)
               `LPC_OFS_LP_CTRL:   lp_ctrl_q   <= i_wdata;
               `LPC_OFS_PIN_CFG:   pin_cfg_q   <= i_wdata;
               `LPC_OFS_SOFT_TRIG: soft_trig_q <= i_wdata;
               `LPC_OFS_BG_CTRL:   bg_ctrl_q   <= i_wdata;
               `LPC_OFS_DATA_EN: begin
                  data_en_q <= i_wdata;
                  // Enable edge restarts the index
                  if (i_wdata[0] && !data_en_q[0]) begin
                     vec_idx_q <= 10'd0;
                  end
               end
               default: ;
            endcase
         end
         // Reads and writes share one index, so a sweep may be either kind
         // Each data access steps the index; mid-vector means invalid
         if ((i_wr || i_rd) && sel_data) begin
            vec_idx_q   <= last_idx ? 10'd0 : vec_idx_q + 10'd1;
            o_vec_valid <= last_idx;
         end
      end
   end

   // Vector storage, one write per data write access
   // No reset here: an array without reset can sit in block memory,
   // which matters at 673 words
   always @(posedge i_clock) begin
      if (i_ce && i_wr && sel_data) begin
         vec_mem[vec_idx_q] <= i_wdata;
      end
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   // Zero outside the answer cycle keeps stale data off the bus
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         o_rdata <= 8'h00;
         if (i_rd) begin
            case (i_addr)
               `LPC_OFS_LP_CTRL:   o_rdata <= lp_ctrl_q;
               `LPC_OFS_PIN_CFG:   o_rdata <= pin_cfg_q;
               `LPC_OFS_SOFT_TRIG: o_rdata <= soft_trig_q;
               `LPC_OFS_BG_CTRL:   o_rdata <= bg_ctrl_q;
               `LPC_OFS_DATA_EN:   o_rdata <= data_en_q;
               `LPC_OFS_STATUS:    o_rdata <= {6'd0, stopped_q, fg_sync_q};
               `LPC_OFS_DATA:
                  o_rdata <= data_en_q[0] ? vec_mem[vec_idx_q] : 8'h00;
               default:            o_rdata <= 8'h00;
            endcase
         end
      end
   end

   // Stopped status: halt in background, done otherwise
   // This flop adds a cycle after the synchronisers; the host polls the
   // status, so the extra latency costs nothing
   always @(posedge i_clock) begin
      if (i_rst) begin
         stopped_q <= 1'b0;
      end else if (i_ce) begin
         stopped_q <= background_recal_enable ? halt_sync_q : fg_sync_q;
      end
   end

   // ---------------------------------------------------------
   // Sleep and wake sequencer
   // ---------------------------------------------------------
   // One core is sequenced here; a wider device repeats this per core.
   // Timing codes are read live, so a code change mid-state alters the
   // count in progress; software should change codes only while off.
   // Binary state codes
   localparam ST_IDLE  = 2'd0;  // Sequencing off
   localparam ST_SLEEP = 2'd1;  // Core asleep
   localparam ST_WAKE  = 2'd2;  // Core settling
   localparam ST_CAL   = 2'd3;  // Calibration request

   reg  [1:0]  state_q;    // Sequencer state
   reg  [41:0] timer_q;    // Cycle counter within a state

   // Low power needs background calibration; otherwise the core stays awake
   wire lp_active = low_power_recal_enable && background_recal_enable;

   // Timer ends or trigger low; timing read live from the codes
   always @(posedge i_clock) begin
      if (i_rst) begin
         state_q      <= ST_IDLE;
         timer_q      <= 42'd0;
         o_core_sleep <= 1'b0;
         o_cal_start  <= 1'b0;
      end else if (i_ce) begin
         o_cal_start <= 1'b0;
         if (!lp_active) begin
            // Leaving low power wakes the core at once
            state_q      <= ST_IDLE;
            timer_q      <= 42'd0;
            o_core_sleep <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  state_q      <= ST_SLEEP;
                  timer_q      <= 42'd0;
                  o_core_sleep <= 1'b1;
               end
               ST_SLEEP: begin
                  // Trigger mode ignores the timer and waits for a low level
                  timer_q <= timer_q + 42'd1;
                  if (triggered_wake_mode ? !cal_trigger
                      : (timer_q >= dly_cnt(sleep_k(sleep_interval_code)))) begin
                     state_q      <= ST_WAKE;
                     timer_q      <= 42'd0;
                     o_core_sleep <= 1'b0;
                  end
               end
               ST_WAKE: begin
                  // Settle time applies in both modes
                  timer_q <= timer_q + 42'd1;
                  if (timer_q >= dly_cnt(wake_k(wake_settle_code))) begin
                     state_q     <= ST_CAL;
                     o_cal_start <= 1'b1;
                  end
               end
               ST_CAL: begin
                  // Back to sleep once the pass is handed off
                  state_q      <= ST_SLEEP;
                  timer_q      <= 42'd0;
                  o_core_sleep <= 1'b1;
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [test/lpc_host_model.sv]
// Host model that drives the register port of the recalibration block
`timescale 1ns/10ps
`default_nettype none
module lpc_host_model (
   // Clock
   input  wire logic       i_clock,
   // Register port towards the device
   output logic [7:0]      o_addr,
   output logic [7:0]      o_wdata,
   output logic            o_wr,
   output logic            o_rd,
   input  wire logic [7:0] i_rdata
);
   logic [7:0] got [673];  // Values seen by the last sweep, read or write

   // Idle bus from time zero
   initial begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   // One-cycle write, data inverted after so nothing stale lingers
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clock);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask

   // One-cycle read, data taken in the following cycle only
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clock);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clock);
      o_rd <= 1'b0;
      #1 d = i_rdata;
   endtask

   // Streamed sweep with the strobe held, never cut short
   // Caller keeps the engine halted throughout
   task automatic sweep(input bit w);
      @(posedge i_clock);
      o_addr <= 8'h71;
      o_wdata <= 8'hA5;
      if (w) o_wr <= 1'b1;
      else o_rd <= 1'b1;
      for (int i = 0; i < 673; i++) begin
         @(posedge i_clock);
         o_wdata <= (i[7:0] + 8'h01) ^ 8'hA5;
         if (i == 672) begin
            o_wr <= 1'b0;
            o_rd <= 1'b0;
         end
         #1 got[i] = i_rdata;
      end
   endtask
   // Short codes below the advised floor keep the run brief
endmodule
`default_nettype wire

// [test/lpc_top_properties.sv]
// Port checker for the recalibration block
`timescale 1ns/10ps
`default_nettype none
module lpc_top_props (
   // Clock and reset
   input wire logic       i_clock,
   input wire logic       i_rst,
   // Register port
   input wire logic       i_ce,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   // Sequencer and vector status
   input wire logic       o_core_sleep,
   input wire logic       o_cal_start,
   input wire logic       o_vec_valid
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // Shadow of the wake-mode bit, kept from host writes to the control register
   logic trig_mode_q;
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         trig_mode_q <= 1'b0;
      end else if (i_ce && i_wr && i_addr == 8'h6E) begin
         trig_mode_q <= i_wdata[1];
      end
   end
   // ----------------------------------------
   // Read port and vector state
   // ----------------------------------------
   a_rdata_idle: assert property ($past(i_ce) && !$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside its slot");
   a_unmapped_zero: assert property (i_ce && i_rd && !(i_addr inside
      {8'h60, 8'h6A, 8'h6B, 8'h6C, 8'h6E, 8'h70, 8'h71}) |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_valid_fall: assert property ($fell(o_vec_valid) |-> $past(i_addr) == 8'h71
      && ($past(i_wr) || $past(i_rd))) else $error("valid fell without access");
   a_valid_rise: assert property ($rose(o_vec_valid) |-> $past(i_addr) == 8'h71
      && ($past(i_wr) || $past(i_rd))) else $error("valid rose without access");
   // ----------------------------------------
   // Sleep and wake sequencing
   // ----------------------------------------
   a_start_pulse: assert property (o_cal_start |=> !o_cal_start)
      else $error("start longer than one cycle");
   a_start_resleep: assert property (o_cal_start |-> !o_core_sleep ##1 o_core_sleep)
      else $error("no return to sleep after start");
   a_wake_settle: assert property ($fell(o_core_sleep) |-> !o_cal_start [*8])
      else $error("start too soon after wake");
   a_sleep_min: assert property ($rose(o_core_sleep) && !trig_mode_q |=> o_core_sleep [*8])
      else $error("sleep too short");
endmodule
bind lpc_top lpc_top_props i_lpc_top_props (.i_clock(i_clock), .i_rst(i_rst),
   .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata),
   .o_core_sleep(o_core_sleep), .o_cal_start(o_cal_start), .o_vec_valid(o_vec_valid));
`default_nettype wire

// [test/lpc_top_tb.sv]
// Self-checking bench for the recalibration block
`timescale 1ns/10ps
`default_nettype none
module lpc_top_tb;
   logic       clk = 1'b0;   // Sample clock
   logic       rst = 1'b1;   // Sync reset
   logic       trig = 1'b1;  // Hardware trigger pin, idle high
   logic       halt = 1'b0;  // Engine halted
   logic       fgd = 1'b0;   // Foreground done
   logic       ce = 1'b1;    // Clock enable
   logic [7:0] addr, wdata, rdata, d;
   logic       wr, rd, sleep, start, vld;
   int         fails = 0;
   int         total_checks = 0;
   int         n;
   logic [7:0] ra [5] = '{8'h6E, 8'h6C, 8'h6B, 8'h70, 8'h55};
   logic [7:0] re [5] = '{8'h88, 8'h01, 8'h00, 8'h00, 8'h00};

   always #12.5 clk = ~clk;

   lpc_host_model i_lpc_host_model (.i_clock(clk), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
   // Clock enable driven so a frozen write can be checked
   lpc_top i_lpc_top (.i_clock(clk), .i_rst(rst), .i_ce(ce), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_hardware_trigger_pin(trig), .i_bg_halted(halt), .i_fg_done(fgd),
      .o_core_sleep(sleep), .o_cal_start(start), .o_vec_valid(vld));

   task automatic print_verdict;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      i_lpc_host_model.rd(a, d);
      chk(d, e);
   endtask

   // Bounded wait on sleep (s=0) or start (s=1); n ends as cycles taken
   task automatic wt(input bit s, input logic v, input int lim);
      n = 0;
      while ((s ? start : sleep) !== v) begin
         @(posedge clk);
         #1 n++;
         if (n > lim) begin
            fails++;
            $display("mismatch at %0t: wait expired", $time);
            print_verdict();
         end
      end
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) rchk(ra[i], re[i]);
      rchk(8'h71, 8'h00);
      // A write while the clock enable is low must not land
      @(posedge clk);
      ce <= 1'b0;
      i_lpc_host_model.wr(8'h6C, 8'h00);
      ce <= 1'b1;
      rchk(8'h6C, 8'h01);
      i_lpc_host_model.wr(8'h6E, 8'h01);
      repeat (20) @(posedge clk);
      #1 chk({7'h0, sleep}, 8'h00);
      halt <= 1'b1;
      fgd <= 1'b1;
      repeat (4) @(posedge clk);
      rchk(8'h6A, 8'h03);
      // Partial write leaves the vector invalid, then restart the index
      i_lpc_host_model.wr(8'h70, 8'h01);
      i_lpc_host_model.wr(8'h71, 8'h3C);
      @(posedge clk);
      #1 chk({7'h0, vld}, 8'h00);
      i_lpc_host_model.wr(8'h70, 8'h00);
      i_lpc_host_model.wr(8'h70, 8'h01);
      i_lpc_host_model.sweep(1'b1);
      @(posedge clk);
      #1 chk({7'h0, vld}, 8'h01);
      // One read moves the index off zero, so the restart below is tested
      rchk(8'h71, 8'hA5);
      i_lpc_host_model.wr(8'h70, 8'h00);
      i_lpc_host_model.wr(8'h70, 8'h01);
      i_lpc_host_model.sweep(1'b0);
      @(posedge clk);
      #1 chk({7'h0, vld}, 8'h01);
      for (int i = 0; i < 673; i++) chk(i_lpc_host_model.got[i], i[7:0] ^ 8'hA5);
      // Autonomous sleep and wake with the shortest codes
      i_lpc_host_model.wr(8'h60, 8'h01);
      wt(0, 1, 10);
      wt(0, 0, 2400);
      chk({7'h0, n >= 2304 && n <= 2306}, 8'h01);
      wt(1, 1, 2400);
      chk({7'h0, n >= 2303 && n <= 2306}, 8'h01);
      // Trigger mode: software bit, then the hardware pin
      i_lpc_host_model.wr(8'h6E, 8'h03);
      wt(0, 1, 5000);
      trig <= 1'b0;  // Pin low must be ignored while software is selected
      repeat (3000) @(posedge clk);
      #1 chk({7'h0, sleep}, 8'h01);
      @(posedge clk);
      trig <= 1'b1;
      i_lpc_host_model.wr(8'h6C, 8'h00);
      wt(0, 0, 8);
      chk({7'h0, sleep}, 8'h00);
      i_lpc_host_model.wr(8'h6C, 8'h01);
      i_lpc_host_model.wr(8'h6B, 8'h01);
      wt(1, 1, 2400);
      wt(0, 1, 4);
      @(posedge clk);
      trig <= 1'b0;
      wt(0, 0, 8);
      chk({7'h0, sleep}, 8'h00);
      @(posedge clk);
      trig <= 1'b1;
      print_verdict();
   end
endmodule
`default_nettype wire
